/* design/jtag_ir_decode.sv */
// Test access port controller, instruction decode and serial data path selection.
module jtag_ir_decode
   import jtag_ir_pkg::*;
#(
   parameter logic [10:0] ID_MANUF   = 11'h155,
   parameter logic [15:0] ID_PART    = 16'h1234,
   parameter logic [3:0]  ID_VERSION = 4'h1
) (
   input  wire logic ref_clk,
   input  wire logic arst_n,
   input  wire logic tck,
   input  wire logic tms,
   input  wire logic tdi,
   output logic      tdo,
   output logic      tdo_oe,
   input  wire logic bsr_so,
   output logic      bsr_si,
   output logic      bsr_capture,
   output logic      bsr_shift,
   output logic      bsr_update,
   output logic      pin_drive_bsr,
   output logic      pin_highz
);

   import jtag_ir_pkg::*;

   // Fields are arbitrary identity values, not those of any real part.
   localparam logic [ID_WIDTH-1:0] ID_VALUE =
      {ID_VERSION, ID_PART, ID_MANUF, ID_FIXED_LSB};

   function automatic logic is_reserved(input logic [IR_WIDTH-1:0] op);
      return !(op == OP_EXTEST || op == OP_SAMPLE || op == OP_IDCODE ||
               op == OP_HIGHZ || op == OP_VALIDATE || op == OP_CLAMP ||
               op == OP_BYPASS);
   endfunction

   logic [2:0]          pins_s;
   logic                tck_s;
   logic                tms_s;
   logic                tdi_s;
   logic                tck_q;
   logic                tck_rise;
   logic                tck_fall;
   tap_state_t          state;
   tap_state_t          next_state;
   logic [IR_WIDTH-1:0] ir_shift;
   logic [IR_WIDTH-1:0] instr;
   logic                sel_bsr;
   logic                sel_id;
   logic                sel_byp;
   logic                op_extest;
   logic                op_highz;
   logic                op_clamp;
   logic                bypass;
   logic [ID_WIDTH-1:0] id_shift;
   logic                ir_capture;
   logic                ir_shift_en;
   logic                ir_update;
   logic                dr_capture;
   logic                dr_shift;
   logic                serial_out;
   logic [2:0]          tms_ones;

   pin_sync #(
      .WIDTH     (3),
      .RESET_VAL (PIN_RESET)
   ) u_sync (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .pin     ({tms, tdi, tck}),
      .level   (pins_s)
   );

   assign tck_s = pins_s[0];
   assign tdi_s = pins_s[1];
   assign tms_s = pins_s[2];

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         tck_q <= 1'b0;
      end else begin
         tck_q <= tck_s;
      end
   end

   assign tck_rise = tck_s & ~tck_q;
   assign tck_fall = ~tck_s & tck_q;

   // Five rising edges with mode select high reach the reset state from anywhere.
   always_comb begin
      next_state = state;
      unique case (state)
         ST_RESET:  next_state = tms_s ? ST_RESET  : ST_IDLE;
         ST_IDLE:   next_state = tms_s ? ST_SEL_DR : ST_IDLE;
         ST_SEL_DR: next_state = tms_s ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: next_state = tms_s ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR:  next_state = tms_s ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: next_state = tms_s ? ST_UP_DR  : ST_PA_DR;
         ST_PA_DR:  next_state = tms_s ? ST_EX2_DR : ST_PA_DR;
         ST_EX2_DR: next_state = tms_s ? ST_UP_DR  : ST_SH_DR;
         ST_UP_DR:  next_state = tms_s ? ST_SEL_DR : ST_IDLE;
         ST_SEL_IR: next_state = tms_s ? ST_RESET  : ST_CAP_IR;
         ST_CAP_IR: next_state = tms_s ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR:  next_state = tms_s ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: next_state = tms_s ? ST_UP_IR  : ST_PA_IR;
         ST_PA_IR:  next_state = tms_s ? ST_EX2_IR : ST_PA_IR;
         ST_EX2_IR: next_state = tms_s ? ST_UP_IR  : ST_SH_IR;
         ST_UP_IR:  next_state = tms_s ? ST_SEL_DR : ST_IDLE;
         default:   next_state = ST_RESET;
      endcase
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= ST_RESET;
      end else if (tck_rise) begin
         state <= next_state;
      end
   end

   // Capture and shift act on the rising edge that leaves the state; updates act on
   // the falling edge inside it, so outputs never change mid-shift.
   assign ir_capture  = tck_rise && state == ST_CAP_IR;
   assign ir_shift_en = tck_rise && state == ST_SH_IR;
   assign ir_update   = tck_fall && state == ST_UP_IR;
   assign dr_capture  = tck_rise && state == ST_CAP_DR;
   assign dr_shift    = tck_rise && state == ST_SH_DR;

   ir_stage u_ir (
      .ref_clk   (ref_clk),
      .arst_n    (arst_n),
      .tap_reset (state == ST_RESET),
      .capture   (ir_capture),
      .shift     (ir_shift_en),
      .update    (ir_update),
      .tdi       (tdi_s),
      .shift_reg (ir_shift),
      .instr     (instr)
   );

   assign op_extest = instr == OP_EXTEST;
   assign op_highz  = instr == OP_HIGHZ;
   assign op_clamp  = instr == OP_CLAMP;
   assign sel_bsr   = op_extest || instr == OP_SAMPLE;
   assign sel_id    = instr == OP_IDCODE;
   assign sel_byp   = !sel_bsr && !sel_id;

   assign bsr_capture = dr_capture && sel_bsr;
   assign bsr_shift   = dr_shift && sel_bsr;
   assign bsr_si      = tdi_s;
   assign bsr_update  = tck_fall && state == ST_UP_DR && sel_bsr;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_drive_bsr <= 1'b0;
         pin_highz     <= 1'b0;
      end else begin
         pin_drive_bsr <= op_extest || op_clamp;
         pin_highz     <= op_highz;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         bypass <= BYPASS_CAPTURE;
      end else if (dr_capture && sel_byp) begin
         bypass <= BYPASS_CAPTURE;
      end else if (dr_shift && sel_byp) begin
         bypass <= tdi_s;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         id_shift <= ID_VALUE;
      end else if (dr_capture && sel_id) begin
         id_shift <= ID_VALUE;
      end else if (dr_shift && sel_id) begin
         id_shift <= {tdi_s, id_shift[ID_WIDTH-1:1]};
      end
   end

   assign serial_out = state == ST_SH_IR ? ir_shift[0] :
                       sel_bsr           ? bsr_so      :
                       sel_id            ? id_shift[0] : bypass;

   // The serial output moves only on falling edges so the tester samples it settled.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         tdo    <= 1'b0;
         tdo_oe <= 1'b0;
      end else if (tck_fall) begin
         tdo    <= serial_out;
         tdo_oe <= state == ST_SH_IR || state == ST_SH_DR;
      end
   end

   // Helper for the reset check; it saturates so a long run of ones stays at the limit.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         tms_ones <= 3'h0;
      end else if (tck_rise && !tms_s) begin
         tms_ones <= 3'h0;
      end else if (tck_rise && tms_ones != 3'(TMS_RESET_RISES)) begin
         tms_ones <= tms_ones + 3'h1;
      end
   end

   a_ir_shift_in: assert property (@(posedge ref_clk) disable iff (!arst_n)
      ir_shift_en |=> ir_shift == {$past(tdi_s), $past(ir_shift[IR_WIDTH-1:1])})
      else $error("instruction shift stage did not take the serial input");

   a_ir_holds: assert property (@(posedge ref_clk) disable iff (!arst_n)
      !ir_update && state != ST_RESET |=> $stable(instr))
      else $error("instruction changed outside update");

   a_ir_update: assert property (@(posedge ref_clk) disable iff (!arst_n)
      ir_update |=> instr == $past(ir_shift))
      else $error("update did not latch the shifted instruction");

   a_validate_cap: assert property (@(posedge ref_clk) disable iff (!arst_n)
      ir_capture |=> ir_shift == OP_VALIDATE && ir_shift[1:0] == 2'h1)
      else $error("capture did not load the validate pattern");

   a_reset_idcode: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (tms_ones == 3'(TMS_RESET_RISES) || state == ST_RESET) |=> instr == OP_IDCODE)
      else $error("controller reset left another instruction current");

   a_one_path: assert property (@(posedge ref_clk) disable iff (!arst_n)
      $onehot({sel_bsr, sel_id, sel_byp}))
      else $error("more or fewer than one data path selected");

   a_bypass_zero: assert property (@(posedge ref_clk) disable iff (!arst_n)
      dr_capture && sel_byp ##1 !tck_fall [*2] |-> bypass == 1'b0)
      else $error("bypass bit did not capture zero");

   a_id_lsb: assert property (@(posedge ref_clk) disable iff (!arst_n)
      dr_capture && sel_id |=> id_shift[0] == ID_FIXED_LSB && id_shift == ID_VALUE)
      else $error("identification capture wrong");

   a_extest_drive: assert property (@(posedge ref_clk) disable iff (!arst_n)
      op_extest |=> pin_drive_bsr && !pin_highz)
      else $error("external test not driving pins from boundary latches");

   a_sample_nodrv: assert property (@(posedge ref_clk) disable iff (!arst_n)
      instr == OP_SAMPLE |=> !pin_drive_bsr && !pin_highz)
      else $error("sample instruction disturbed the pins");

   a_highz_out: assert property (@(posedge ref_clk) disable iff (!arst_n)
      op_highz |=> pin_highz && !pin_drive_bsr)
      else $error("high impedance not forced");

   a_clamp_path: assert property (@(posedge ref_clk) disable iff (!arst_n)
      op_clamp |-> sel_byp && !bsr_shift ##1 pin_drive_bsr)
      else $error("clamp path or pin drive wrong");

   a_reserved_byp: assert property (@(posedge ref_clk) disable iff (!arst_n)
      is_reserved(instr) |-> sel_byp ##1 !pin_drive_bsr && !pin_highz)
      else $error("reserved opcode not in bypass with functional pins");

   a_bsr_gated: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (bsr_capture || bsr_shift || bsr_update) |-> sel_bsr)
      else $error("boundary chain strobed while unselected");

   a_tdo_enable: assert property (@(posedge ref_clk) disable iff (!arst_n)
      tck_fall |=> tdo_oe == ($past(state) == ST_SH_IR || $past(state) == ST_SH_DR))
      else $error("serial output enable wrong");

endmodule

/* design/jtag_ir_pkg.sv */
// Constants, opcodes and controller states for the test port instruction decoder.
package jtag_ir_pkg;

   localparam int IR_WIDTH = 6;
   localparam int ID_WIDTH = 32;

   localparam logic [IR_WIDTH-1:0] OP_EXTEST   = 6'h00;
   localparam logic [IR_WIDTH-1:0] OP_SAMPLE   = 6'h01;
   localparam logic [IR_WIDTH-1:0] OP_IDCODE   = 6'h02;
   localparam logic [IR_WIDTH-1:0] OP_HIGHZ    = 6'h03;
   localparam logic [IR_WIDTH-1:0] OP_VALIDATE = 6'h2D;
   localparam logic [IR_WIDTH-1:0] OP_CLAMP    = 6'h3E;
   localparam logic [IR_WIDTH-1:0] OP_BYPASS   = 6'h3F;

   localparam int ID_MANUF_LSB = 1;
   localparam int ID_PART_LSB  = 12;
   localparam int ID_VER_LSB   = 28;
   localparam logic ID_FIXED_LSB = 1'b1;
   localparam logic BYPASS_CAPTURE = 1'b0;
   // Consecutive test clock rises with mode select high that must end in reset.
   localparam int TMS_RESET_RISES = 5;

   // Pin inputs are idle-high (pull-ups) except the test clock, which rests low.
   localparam logic [2:0] PIN_RESET = 3'h6;

   typedef enum logic [15:0] {
      ST_RESET  = 16'h0001,
      ST_IDLE   = 16'h0002,
      ST_SEL_DR = 16'h0004,
      ST_CAP_DR = 16'h0008,
      ST_SH_DR  = 16'h0010,
      ST_EX1_DR = 16'h0020,
      ST_PA_DR  = 16'h0040,
      ST_EX2_DR = 16'h0080,
      ST_UP_DR  = 16'h0100,
      ST_SEL_IR = 16'h0200,
      ST_CAP_IR = 16'h0400,
      ST_SH_IR  = 16'h0800,
      ST_EX1_IR = 16'h1000,
      ST_PA_IR  = 16'h2000,
      ST_EX2_IR = 16'h4000,
      ST_UP_IR  = 16'h8000
   } tap_state_t;

endpackage

/* design/pin_sync.sv */
// Three-stage synchroniser that accepts a new level once stages two and three agree.
module pin_sync #(
   parameter int               WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire logic             ref_clk,
   input  wire logic             arst_n,
   input  wire logic [WIDTH-1:0] pin,
   output logic      [WIDTH-1:0] level
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         stage1 <= RESET_VAL;
         stage2 <= RESET_VAL;
         stage3 <= RESET_VAL;
      end else begin
         stage1 <= pin;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // Each bit is filtered on its own so one slow line cannot hold the others back.
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
               level[i] <= RESET_VAL[i];
            end else if (stage2[i] == stage3[i]) begin
               level[i] <= stage3[i];
            end
         end
      end
   endgenerate

endmodule

/* design/ir_stage.sv */
// Six-bit instruction shift stage with its update latch.
module ir_stage
   import jtag_ir_pkg::*;
(
   input  wire logic                ref_clk,
   input  wire logic                arst_n,
   input  wire logic                tap_reset,
   input  wire logic                capture,
   input  wire logic                shift,
   input  wire logic                update,
   input  wire logic                tdi,
   output logic [IR_WIDTH-1:0]      shift_reg,
   output logic [IR_WIDTH-1:0]      instr
);

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         shift_reg <= OP_VALIDATE;
      end else if (capture) begin
         shift_reg <= OP_VALIDATE;
      end else if (shift) begin
         shift_reg <= {tdi, shift_reg[IR_WIDTH-1:1]};
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         instr <= OP_IDCODE;
      end else if (tap_reset) begin
         instr <= OP_IDCODE;
      end else if (update) begin
         instr <= shift_reg;
      end
   end

endmodule

/* verif/scan_tester.sv */
// Board tester model that clocks the test port one bit at a time.
module scan_tester (
   input  wire logic ref_clk,
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo,
   input  wire logic tdo_oe
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end

   // Mode and data change only with the clock fall, so both stay put four cycles
   // either side of each rise. Read data is taken just before the next fall.
   task automatic step(input logic m, input logic d, output logic q);
      @(posedge ref_clk);
      tck <= 1'b0;
      tms <= m;
      tdi <= d;
      repeat (4) @(posedge ref_clk);
      tck <= 1'b1;
      repeat (3) @(posedge ref_clk);
      #1;
      q = tdo_oe ? tdo : 1'bz;
   endtask

   // The test clock stands low between frames.
   task automatic park();
      @(posedge ref_clk);
      tck <= 1'b0;
      repeat (8) @(posedge ref_clk);
   endtask
endmodule

/* verif/tb.sv */
// Self-checking bench for the test port instruction decoder.
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import jtag_ir_pkg::*;

   // Identification fields below are arbitrary values.
   localparam logic [31:0] ID_EXP  = {4'h6, 16'h5C3A, 11'h2AA, 1'b1};
   localparam logic [7:0]  CAP_PAT = 8'hC9;
   localparam logic [7:0]  DIN     = 8'h5A;

   logic       ref_clk;
   logic       arst_n;
   logic       tck;
   logic       tms;
   logic       tdi;
   logic       tdo;
   logic       tdo_oe;
   logic       bsr_so;
   logic       bsr_si;
   logic       bsr_capture;
   logic       bsr_shift;
   logic       bsr_update;
   logic       pin_drive_bsr;
   logic       pin_highz;
   logic [7:0] bsr;
   logic       q;
   int         updates;
   int         mismatches;
   int         checked;

   initial ref_clk = 1'b0;
   always #10 ref_clk = ~ref_clk;

   jtag_ir_decode #(.ID_MANUF(11'h2AA), .ID_PART(16'h5C3A), .ID_VERSION(4'h6)) uut (
      .ref_clk(ref_clk), .arst_n(arst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
      .tdo_oe(tdo_oe), .bsr_so(bsr_so), .bsr_si(bsr_si), .bsr_capture(bsr_capture),
      .bsr_shift(bsr_shift), .bsr_update(bsr_update), .pin_drive_bsr(pin_drive_bsr),
      .pin_highz(pin_highz));

   scan_tester tester (.ref_clk(ref_clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
                       .tdo_oe(tdo_oe));

   // Eight-cell stand-in for the boundary chain; a capture loads a fixed pattern.
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         bsr <= 8'h00;
         updates <= 0;
      end else begin
         if (bsr_capture)
            bsr <= CAP_PAT;
         else if (bsr_shift)
            bsr <= {bsr_si, bsr[7:1]};
         if (bsr_update)
            updates <= updates + 1;
      end
   end
   assign bsr_so = bsr[0];

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic ir_scan(input logic [5:0] op, input logic drive_before);
      logic [5:0] got;
      tester.step(1'b1, 1'b1, q);
      tester.step(1'b1, 1'b1, q);
      tester.step(1'b0, 1'b1, q);
      tester.step(1'b0, 1'b1, q);
      for (int i = 0; i < IR_WIDTH; i++) begin
         tester.step(i == IR_WIDTH - 1, op[i], got[i]);
      end
      chk("ir capture", OP_VALIDATE, got);
      chk("drive before update", drive_before, pin_drive_bsr);
      tester.step(1'b1, 1'b1, q);
      tester.step(1'b0, 1'b1, q);
      tester.park();
   endtask

   task automatic dr_scan(input int n, input logic [31:0] din, output logic [31:0] dout);
      dout = '0;
      tester.step(1'b1, 1'b1, q);
      tester.step(1'b0, 1'b1, q);
      tester.step(1'b0, 1'b1, q);
      for (int i = 0; i < n; i++) begin
         tester.step(i == n - 1, din[i], dout[i]);
      end
      tester.step(1'b1, 1'b1, q);
      tester.step(1'b0, 1'b1, q);
      tester.park();
   endtask

   task automatic t_reset_id();
      logic [31:0] v;
      tester.step(1'b0, 1'b1, q);
      dr_scan(32, 32'hFFFF0000, v);
      chk("id after reset", ID_EXP, v);
      $display("test reset_id done");
   endtask

   task automatic t_opcodes();
      // Sample comes first so the boundary latches hold known values before external test.
      // preload before drive
      logic [5:0] ops [11] = '{OP_SAMPLE, OP_EXTEST, OP_IDCODE, OP_HIGHZ, OP_VALIDATE,
                               OP_CLAMP, OP_BYPASS, 6'h04, 6'h2C, 6'h2E, 6'h3D};
      logic        drive;
      logic        bnd;
      logic        drv;
      logic [7:0]  exp;
      logic [31:0] v;
      int          u;
      drive = 1'b0;
      foreach (ops[k]) begin
         bnd = ops[k] == OP_SAMPLE || ops[k] == OP_EXTEST;
         drv = ops[k] == OP_EXTEST || ops[k] == OP_CLAMP;
         exp = bnd ? CAP_PAT : (ops[k] == OP_IDCODE) ? ID_EXP[7:0] : {DIN[6:0], 1'b0};
         ir_scan(ops[k], drive);
         repeat (4) @(posedge ref_clk);
         chk("pin drive", drv, pin_drive_bsr);
         chk("pin highz", ops[k] == OP_HIGHZ, pin_highz);
         u = updates;
         dr_scan(8, DIN, v);
         chk("dr path", exp, v[7:0]);
         chk("boundary updates", bnd, updates - u);
         drive = drv;
      end
      $display("test opcodes done");
   endtask

   task automatic t_resets();
      logic [31:0] v;
      ir_scan(OP_EXTEST, 1'b0);
      repeat (5) tester.step(1'b1, 1'b1, q);
      tester.step(1'b0, 1'b1, q);
      tester.park();
      chk("drive after tms reset", 1'b0, pin_drive_bsr);
      dr_scan(32, 32'h0, v);
      chk("id after tms reset", ID_EXP, v);
      ir_scan(OP_CLAMP, 1'b0);
      @(posedge ref_clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      arst_n <= 1'b1;
      chk("drive after reset", 1'b0, pin_drive_bsr);
      chk("tdo enable after reset", 1'b0, tdo_oe);
      tester.step(1'b0, 1'b1, q);
      dr_scan(32, 32'h0, v);
      chk("id after async reset", ID_EXP, v);
      $display("test resets done");
   endtask

   initial begin
      repeat (30000) @(posedge ref_clk);
      mismatches++;
      $display("BAD watchdog expected finish seen hang");
      finish_test();
   end

   initial begin
      mismatches = 0;
      checked = 0;
      arst_n = 1'b0;
      repeat (8) @(posedge ref_clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      t_reset_id();
      t_opcodes();
      t_resets();
      finish_test();
   end
endmodule
